// *** hdl/cmd_defines.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef CMD_DEFINES_SVH
`define CMD_DEFINES_SVH
`define CMD_ADDR_W            8
`define CMD_OFS_CHROMA_BW     8'h10
`define CMD_OFS_MODE_DELAY    8'h11
`define CMD_RST_CHROMA_BW     8'h00
`define CMD_RST_MODE_DELAY    8'h00
`define CMD_BLUE_OFS_MSB      7
`define CMD_BLUE_OFS_LSB      6
`define CMD_RED_OFS_MSB       5
`define CMD_RED_OFS_LSB       4
`define CMD_CHROMA_WIDE_BIT   3
`define CMD_BAND_SPLIT_MSB    2
`define CMD_BAND_SPLIT_LSB    0
`define CMD_COLOUR_ON_BIT     7
`define CMD_OUT1_INV_BIT      6
`define CMD_HS_DEL_MSB        5
`define CMD_HS_DEL_LSB        4
`define CMD_OUT0_INV_BIT      3
`define CMD_LUMA_DEL_MSB      2
`define CMD_LUMA_DEL_LSB      0
`define CMD_LLC_PER_STEP      2
`define CMD_LLC_PER_WIDTH     8
`endif

// *** hdl/cmd_pkg.sv ***
// types shared by the chroma mode delay control block
package cmd_pkg;
  typedef struct packed {
    logic       wr;     // write strobe
    logic [7:0] addr;   // register subaddress
    logic [7:0] wdata;  // write data
  } cmd_reg_req_type;

  typedef struct packed {
    logic [1:0] blue_diff_fine_offset;
    logic [1:0] red_diff_fine_offset;
    logic       chroma_wide_select;
    logic [2:0] luma_chroma_band_split;
    logic       colour_force_on;
    logic [1:0] hsync_fine_delay;
    logic [2:0] luma_delay_comp;
  } cmd_ctrl_type;
endpackage : cmd_pkg

// *** hdl/cmd_top.sv ***
// chroma offset, bandwidth, mode and delay control registers with their datapath effects
`timescale 1ns/100ps
`include "cmd_defines.svh"
module cmd_top #(
  parameter int DW     = 10,  // chroma sample width, integer part
  parameter int MAXDEL = 16   // luma delay line depth in clocks
) (
  input  wire logic                     clk,           // line locked clock, 10 MHz
  input  wire logic                     rst_n,         // async reset, active low
  input  wire cmd_pkg::cmd_reg_req_type reg_req,       // register write/read request
  output logic [7:0]                    reg_rdata,     // read data for addressed register
  input  wire logic [DW-1:0]            blue_diff_in,  // b-y sample
  input  wire logic [DW-1:0]            red_diff_in,   // r-y sample
  output logic [DW+1:0]                 blue_diff_out, // b-y with 2 fraction bits
  output logic [DW+1:0]                 red_diff_out,  // r-y with 2 fraction bits
  input  wire logic [7:0]               luma_in,       // luma sample
  output logic [7:0]                    luma_out,      // delay compensated luma
  input  wire logic                     colour_detect, // automatic killer says colour
  output logic                          colour_enable, // chroma pass enable
  output cmd_pkg::cmd_ctrl_type         ctrl,          // fields to filters
  input  wire logic                     hs_start,      // raw hsync start pulse
  input  wire logic [7:0]               hs_width,      // hsync width in 8-clock units
  output logic                          horizontal_sync_pulse, // shaped hsync
  input  wire logic                     status_sel0,   // raw signal for first output
  input  wire logic                     status_sel1,   // raw signal for second output
  output logic                          status_out0,   // first real-time status
  output logic                          status_out1    // second real-time status
);
  import cmd_pkg::*;

  // luma line base tap and hsync counter width
  localparam int NBASE = 8;  // luma base delay so negative steps are reachable
  localparam int CW    = 12;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] cbw_q, cbw_d, mdc_q, mdc_d;

  // write decode for the two control registers
  always_comb begin
    cbw_d = cbw_q;
    mdc_d = mdc_q;
    if (reg_req.wr && reg_req.addr == `CMD_OFS_CHROMA_BW) begin
      cbw_d = reg_req.wdata;
    end
    if (reg_req.wr && reg_req.addr == `CMD_OFS_MODE_DELAY) begin
      mdc_d = reg_req.wdata;
    end
  end

  // register storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cbw_q <= `CMD_RST_CHROMA_BW;
      mdc_q <= `CMD_RST_MODE_DELAY;
    end else begin
      cbw_q <= cbw_d;
      mdc_q <= mdc_d;
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    unique case (reg_req.addr)
      `CMD_OFS_CHROMA_BW:  reg_rdata = cbw_q;
      `CMD_OFS_MODE_DELAY: reg_rdata = mdc_q;
      default:             reg_rdata = 8'h00;
    endcase
  end

  // field breakout to the filter datapath
  always_comb begin
    ctrl.blue_diff_fine_offset  = cbw_q[`CMD_BLUE_OFS_MSB:`CMD_BLUE_OFS_LSB];
    ctrl.red_diff_fine_offset   = cbw_q[`CMD_RED_OFS_MSB:`CMD_RED_OFS_LSB];
    ctrl.chroma_wide_select     = cbw_q[`CMD_CHROMA_WIDE_BIT];
    ctrl.luma_chroma_band_split = cbw_q[`CMD_BAND_SPLIT_MSB:`CMD_BAND_SPLIT_LSB];
    ctrl.colour_force_on        = mdc_q[`CMD_COLOUR_ON_BIT];
    ctrl.hsync_fine_delay       = mdc_q[`CMD_HS_DEL_MSB:`CMD_HS_DEL_LSB];
    ctrl.luma_delay_comp        = mdc_q[`CMD_LUMA_DEL_MSB:`CMD_LUMA_DEL_LSB];
  end

  // ----------------------------------------------------------------
  // chroma offset, colour kill and status polarity
  // ----------------------------------------------------------------
  logic [DW+1:0] bo_d, bo_q, ro_d, ro_q;
  logic          ce_d, ce_q, s0_d, s0_q, s1_d, s1_q;

  // fine offset appended as two fraction bits; kill blanks chroma
  always_comb begin
    bo_d = {blue_diff_in, 2'h0} + {{DW{1'b0}}, ctrl.blue_diff_fine_offset};
    ro_d = {red_diff_in, 2'h0} + {{DW{1'b0}}, ctrl.red_diff_fine_offset};
    ce_d = ctrl.colour_force_on | colour_detect;
    s0_d = status_sel0 ^ mdc_q[`CMD_OUT0_INV_BIT];
    s1_d = status_sel1 ^ mdc_q[`CMD_OUT1_INV_BIT];
  end

  // chroma, enable and status registers, one cycle of latency
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bo_q <= '0;
      ro_q <= '0;
      ce_q <= 1'b0;
      s0_q <= 1'b0;
      s1_q <= 1'b0;
    end else begin
      bo_q <= bo_d;
      ro_q <= ro_d;
      ce_q <= ce_d;
      s0_q <= s0_d;
      s1_q <= s1_d;
    end
  end

  // killed chroma reads zero so downstream sees no colour
  assign blue_diff_out = ce_q ? bo_q : '0;
  assign red_diff_out  = ce_q ? ro_q : '0;
  assign colour_enable = ce_q;
  assign status_out0   = s0_q;
  assign status_out1   = s1_q;

  // ----------------------------------------------------------------
  // luma delay compensation
  // ----------------------------------------------------------------
  logic [7:0] ly_q [MAXDEL];
  logic [7:0] ly_d [MAXDEL];
  logic [7:0] lo_d, lo_q;
  int         tap;

  // shift line; tap = base + 2 * signed step
  always_comb begin
    ly_d[0] = luma_in;
    for (int i = 1; i < MAXDEL; i++) begin
      ly_d[i] = ly_q[i-1];
    end
    tap  = NBASE + `CMD_LLC_PER_STEP * $signed(ctrl.luma_delay_comp);
    lo_d = ly_q[tap[3:0]];
  end

  // one register per tap of the luma line
  genvar g;
  generate
    for (g = 0; g < MAXDEL; g++) begin : g_ly
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ly_q[g] <= 8'h00;
        end else begin
          ly_q[g] <= ly_d[g];
        end
      end
    end
  endgenerate

  // output register adds one cycle on top of the selected tap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_q <= 8'h00;
    end else begin
      lo_q <= lo_d;
    end
  end
  assign luma_out = lo_q;

  // ----------------------------------------------------------------
  // hsync shaping
  // ----------------------------------------------------------------
  logic [CW-1:0] dc_d, dc_q, wc_d, wc_q;
  logic          dly_d, dly_q, hs_d, hs_q;

  // fine delay count then width count in eight-clock units
  always_comb begin
    dc_d  = dc_q;
    dly_d = dly_q;
    wc_d  = wc_q;
    hs_d  = hs_q;
    if (hs_start) begin
      dly_d = 1'b1;
      dc_d  = CW'(`CMD_LLC_PER_STEP * ctrl.hsync_fine_delay);
    end else if (dly_q) begin
      if (dc_q == '0) begin
        dly_d = 1'b0;
        hs_d  = (hs_width != 8'h00);
        wc_d  = CW'(`CMD_LLC_PER_WIDTH * hs_width) - CW'(1);
      end else begin
        dc_d = dc_q - CW'(1);
      end
    end else if (hs_q) begin
      if (wc_q == '0) begin
        hs_d = 1'b0;
      end else begin
        wc_d = wc_q - CW'(1);
      end
    end
  end

  // hsync counters and level register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dc_q  <= '0;
      wc_q  <= '0;
      dly_q <= 1'b0;
      hs_q  <= 1'b0;
    end else begin
      dc_q  <= dc_d;
      wc_q  <= wc_d;
      dly_q <= dly_d;
      hs_q  <= hs_d;
    end
  end
  assign horizontal_sync_pulse = hs_q;
endmodule : cmd_top

// *** verif/cmd_top_asserts.sv ***
// concurrent checks on the ports of the control block
`timescale 1ns/100ps
module cmd_top_asserts
  import cmd_pkg::*;
#(
  parameter int DW = 10 // sample width
) (
  input wire logic            clk,                   // clock
  input wire logic            rst_n,                 // reset
  input wire cmd_reg_req_type reg_req,               // write request
  input wire logic [7:0]      reg_rdata,             // read data
  input wire logic [DW-1:0]   blue_diff_in,          // b-y in
  input wire logic [DW-1:0]   red_diff_in,           // r-y in
  input wire logic [DW+1:0]   blue_diff_out,         // b-y out
  input wire logic [DW+1:0]   red_diff_out,          // r-y out
  input wire logic            colour_detect,         // killer input
  input wire logic            colour_enable,         // chroma enable
  input wire cmd_ctrl_type    ctrl,                  // filter fields
  input wire logic            hs_start,              // raw sync
  input wire logic            horizontal_sync_pulse, // shaped sync
  input wire logic            status_sel0,           // raw status 0
  input wire logic            status_sel1,           // raw status 1
  input wire logic            status_out0,           // status 0
  input wire logic            status_out1            // status 1
);
  logic [7:0] chr_q, mod_q, cnt_q;
  // shadow registers and cycles since the last sync start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chr_q <= 8'h00;
      mod_q <= 8'h00;
      cnt_q <= 8'h00;
    end else begin
      if (reg_req.wr && reg_req.addr == 8'h10) chr_q <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == 8'h11) mod_q <= reg_req.wdata;
      cnt_q <= hs_start ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hFF};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_hs_rise;
    !horizontal_sync_pulse ##1 horizontal_sync_pulse;
  endsequence
  AST_OUT0: assert property (
    $past(rst_n) |-> status_out0 == ($past(status_sel0) ^ $past(mod_q[3]))) else $error("out0");
  AST_OUT1: assert property (
    $past(rst_n) |-> status_out1 == ($past(status_sel1) ^ $past(mod_q[6]))) else $error("out1");
  AST_COLOUR: assert property (
    $past(rst_n) |-> colour_enable == ($past(colour_detect) | $past(mod_q[7])))
    else $error("colour enable");
  AST_CTRL: assert property (
    ctrl == {chr_q, mod_q[7], mod_q[5:4], mod_q[2:0]}) else $error("ctrl fields");
  AST_RDATA: assert property (
    reg_rdata == (reg_req.addr == 8'h10 ? chr_q : reg_req.addr == 8'h11 ? mod_q : 8'h00))
    else $error("read data");
  AST_OFFSET: assert property (
    $past(rst_n) && colour_enable && $past(colour_enable) |->
    blue_diff_out == $past({blue_diff_in, 2'b00} + chr_q[7:6]) &&
    red_diff_out == $past({red_diff_in, 2'b00} + chr_q[5:4])) else $error("offset");
  AST_KILL: assert property (
    !colour_enable && !$past(colour_enable) |-> blue_diff_out == '0 && red_diff_out == '0)
    else $error("kill");
  AST_HS: assert property (
    s_hs_rise |-> cnt_q == {5'h00, mod_q[5:4], 1'b0} + 8'h01) else $error("sync position");
endmodule : cmd_top_asserts

// *** verif/chroma_mode_delay_control_bench.sv ***
// self-checking bench for the chroma mode delay control block
`timescale 1ns/100ps
module chroma_mode_delay_control_bench;
  import cmd_pkg::*;
  cmd_reg_req_type reg_req;
  cmd_ctrl_type    ctrl;
  logic            clk, rst_n, colour_detect, colour_enable, hs_start, horizontal_sync_pulse;
  logic            status_sel0, status_sel1, status_out0, status_out1;
  logic [7:0]      reg_rdata, luma_in, luma_out, hs_width;
  logic [9:0]      blue_diff_in, red_diff_in;
  logic [11:0]     blue_diff_out, red_diff_out;
  int              n_errors, check_count, n;
  cmd_top DUT (.clk, .rst_n, .reg_req, .reg_rdata, .blue_diff_in, .red_diff_in,
    .blue_diff_out, .red_diff_out, .luma_in, .luma_out, .colour_detect, .colour_enable,
    .ctrl, .hs_start, .hs_width, .horizontal_sync_pulse, .status_sel0, .status_sel1,
    .status_out0, .status_out1);
  always #50 clk = ~clk;
  // compare and count
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // register write, returns on a clock edge
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_req <= '{1'b1, a, d};
    @(posedge clk);
    reg_req <= '{1'b0, a, d};
    @(posedge clk);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    reg_req <= '{1'b0, a, 8'h00};
    @(posedge clk);
    #1 chk("rdata", {8'h00, exp}, {8'h00, reg_rdata});
    @(posedge clk);
  endtask : rd
  task automatic test_regs;
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h00);
    wr(8'h10, 8'hA5);
    wr(8'h11, 8'h5A);
    wr(8'h12, 8'hFF);
    rd(8'h10, 8'hA5);
    rd(8'h11, 8'h5A);
    rd(8'h12, 8'h00);
    $display("test_regs done");
  endtask : test_regs
  task automatic test_status;
    for (int i = 0; i < 4; i++) begin
      wr(8'h11, i[1] ? 8'h48 : 8'h00);
      status_sel0 <= i[0];
      status_sel1 <= !i[0];
      repeat (2) @(posedge clk);
      #1 chk("out0", i[0] ^ i[1], status_out0);
      chk("out1", !i[0] ^ i[1], status_out1);
      @(posedge clk);
    end
    $display("test_status done");
  endtask : test_status
  task automatic test_colour;
    blue_diff_in <= 10'h155;
    red_diff_in <= 10'h2AA;
    for (int i = 0; i < 3; i++) begin
      wr(8'h11, i[1] ? 8'h80 : 8'h00);
      colour_detect <= i[0];
      repeat (2) @(posedge clk);
      #1 chk("colour", i[0] | i[1], colour_enable);
      if (i == 0) chk("kill", 16'h0000, blue_diff_out);
      @(posedge clk);
    end
    for (int o = 0; o < 4; o++) begin
      wr(8'h10, 8'(o * 8'h50));
      repeat (2) @(posedge clk);
      #1 chk("blue", {10'h155, 2'b00} + o, blue_diff_out);
      chk("red", {10'h2AA, 2'b00} + o, red_diff_out);
      @(posedge clk);
    end
    $display("test_colour done");
  endtask : test_colour
  task automatic test_luma;
    for (int c = 0; c < 8; c++) begin
      wr(8'h11, 8'(c));
      repeat (20) @(posedge clk);
      luma_in <= 8'hA5;
      n = 0;
      do begin
        @(posedge clk);
        luma_in <= 8'h00;
        n++;
        #1;
      end while (luma_out !== 8'hA5 && n < 30);
      chk("luma delay", 10 + 2 * $signed(3'(c)), n);
      @(posedge clk);
    end
    $display("test_luma done");
  endtask : test_luma
  task automatic test_hs;
    hs_width <= 8'h02;
    for (int d = 0; d < 4; d++) begin
      wr(8'h11, 8'(d * 16));
      hs_start <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        hs_start <= 1'b0;
        n++;
        #1;
      end while (horizontal_sync_pulse !== 1'b1 && n < 40);
      chk("sync position", 2 * d + 2, n);
      n = 0;
      do begin
        @(posedge clk);
        n++;
        #1;
      end while (horizontal_sync_pulse === 1'b1 && n < 40);
      chk("sync width", 16, n);
      @(posedge clk);
    end
    hs_width <= 8'h00;
    hs_start <= 1'b1;
    n = 0;
    repeat (20) begin
      @(posedge clk);
      hs_start <= 1'b0;
      #1 n += int'(horizontal_sync_pulse === 1'b1);
    end
    chk("sync width zero", 0, n);
    $display("test_hs done");
  endtask : test_hs
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  initial begin
    {clk, rst_n, colour_detect, hs_start, status_sel0, status_sel1} = '0;
    {reg_req, luma_in, hs_width, blue_diff_in, red_diff_in} = '0;
    {n_errors, check_count} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    test_regs();
    test_status();
    test_colour();
    test_luma();
    test_hs();
    tally_and_finish();
  end
  // watchdog: about seven times the expected run
  initial begin
    #300000;
    n_errors++;
    tally_and_finish();
  end
endmodule : chroma_mode_delay_control_bench
bind cmd_top cmd_top_asserts #(.DW(DW)) u_chk (.clk, .rst_n, .reg_req, .reg_rdata,
  .blue_diff_in, .red_diff_in, .blue_diff_out, .red_diff_out, .colour_detect,
  .colour_enable, .ctrl, .hs_start, .horizontal_sync_pulse, .status_sel0, .status_sel1,
  .status_out0, .status_out1);
